/* File: rtl/flash_seq_pkg.sv */
// package: opcodes, frame lengths, region sizes, timing and states
// assumes a 100 MHz system clock; the serial clock is a separate domain
`default_nettype none

package flash_seq_pkg;

  // ==========================================================================
  // command opcodes
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_FULL_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_ARRAY_ERASE      = 8'h60;
  localparam logic [7:0] OP_PAGE_WRITE       = 8'h02;
  localparam logic [7:0] OP_SLEEP_ENTRY      = 8'hb9;
  localparam logic [7:0] OP_SIGNATURE        = 8'hab;
  localparam logic [7:0] OP_WRITE_UNLOCK     = 8'h06;

  // ==========================================================================
  // frame layout, counted in whole bytes including the opcode
  localparam logic [2:0] OPCODE_ONLY_BYTES = 3'h1;
  localparam logic [2:0] ADDR_FRAME_BYTES  = 3'h4;
  localparam logic [2:0] FIRST_DATA_BYTES  = 3'h5;
  localparam logic [2:0] BYTE_CNT_MAX      = 3'h7;

  // ==========================================================================
  // address space and region sizes
  localparam int         ADDR_W           = 24;
  localparam int         PAGE_BYTES       = 256;
  localparam logic [23:0] HALF_BLOCK_MASK = 24'h00_7fff;
  localparam logic [23:0] FULL_BLOCK_MASK = 24'h00_ffff;
  localparam logic [23:0] PAGE_MASK       = 24'h00_00ff;
  localparam logic [23:0] ARRAY_BYTES     = 24'h02_0000;
  localparam logic [31:0] PROTECT_UNIT    = 32'h0000_1000;

  // ==========================================================================
  // value returned by the signature read; arbitrary
  localparam logic [7:0] SIGNATURE_VALUE = 8'h5a;

  // ==========================================================================
  // timing; times in microseconds, counts in system clock cycles
  localparam int CLK_MHZ                   = 100;
  localparam int HALF_BLOCK_ERASE_TIME_US  = 200000;
  localparam int FULL_BLOCK_ERASE_TIME_US  = 400000;
  localparam int ARRAY_ERASE_TIME_US       = 2000000;
  localparam int PAGE_WRITE_TIME_US        = 3000;
  localparam int SLEEP_ENTRY_DELAY_US      = 10;
  localparam int SLEEP_EXIT_DELAY_US       = 30;
  localparam int HALF_BLOCK_ERASE_CYCLES   = HALF_BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int FULL_BLOCK_ERASE_CYCLES   = FULL_BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int ARRAY_ERASE_CYCLES        = ARRAY_ERASE_TIME_US * CLK_MHZ;
  localparam int PAGE_WRITE_CYCLES         = PAGE_WRITE_TIME_US * CLK_MHZ;
  localparam logic [31:0] SLEEP_ENTRY_CYCLES = 32'(SLEEP_ENTRY_DELAY_US * CLK_MHZ);
  localparam logic [31:0] SLEEP_EXIT_CYCLES  = 32'(SLEEP_EXIT_DELAY_US * CLK_MHZ);

  // ==========================================================================
  // device power/cycle state and array operation kinds
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_BUSY,
    ST_SLEEP_ENTER,
    ST_SLEEP,
    ST_SLEEP_EXIT
  } dev_state_e;

  typedef enum logic [1:0] {
    ARR_HALF_BLOCK,
    ARR_FULL_BLOCK,
    ARR_WHOLE,
    ARR_PAGE
  } array_op_e;

endpackage

`default_nettype wire

/* File: rtl/flash_cmd_seq.sv */
// serial flash command sequencer: erase, page write, sleep, signature
// assumes sclk idles while cs_n is high and the array follows array_start
//
// Overview of operation
// - half block erase sets block to ones
// - address erase needs cs rise on boundary
// - cycle starts at cs rise, busy, then unlock clears
// - protected half block: no change, unlock cleared
// - full block erase, same framing as half
// - protected full block is not erased
// - array erase is opcode only
// - array erase only with protect bits zero
// - page write programs one to 256 bytes
// - over 256 bytes keeps the last 256
// - data wraps inside the addressed page
// - page write needs cs rise after data byte
// - write cycle timed, busy, protected page skipped
// - sleep entry only on exact opcode frame
// - after delay sleep ignores all but release
// - release or reset returns to standby
// - release waits exit delay when asleep
// - signature repeats while clocks continue
// - release and signature refused while busy
// - bits sampled on rising serial clock
`default_nettype none

module flash_cmd_seq
  import flash_seq_pkg::*;
#(
  parameter int unsigned HALF_BLOCK_ERASE_CNT = HALF_BLOCK_ERASE_CYCLES,
  parameter int unsigned FULL_BLOCK_ERASE_CNT = FULL_BLOCK_ERASE_CYCLES,
  parameter int unsigned ARRAY_ERASE_CNT      = ARRAY_ERASE_CYCLES,
  parameter int unsigned PAGE_WRITE_CNT       = PAGE_WRITE_CYCLES
)
(
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  input  wire logic [1:0]                    bidir_data_lines_in,
  output logic      [1:0]                    bidir_data_lines_out,
  output logic      [1:0]                    bidir_data_lines_oe,
  input  wire logic [3:0]                    protect_range_bits,
  output logic                               write_unlock_latch,
  output logic                               cycle_busy_flag,
  output logic                               sleep_state,
  output logic                               array_start,
  output flash_seq_pkg::array_op_e           array_kind,
  output logic      [flash_seq_pkg::ADDR_W-1:0] array_addr,
  input  wire logic [7:0]                    page_rd_idx,
  output logic      [7:0]                    page_rd_data,
  output logic                               page_rd_mark
);

  import flash_seq_pkg::*;

  // ==========================================================================
  // serial clock domain: frame capture
  logic             first_r;
  logic [6:0]       sh_r;
  logic [2:0]       bit_pos_r;
  logic [2:0]       byte_cnt_r;
  logic [7:0]       opcode_r;
  logic [23:0]      addr_r;
  logic             frame_tog_r;
  logic             busy_l1_r;
  logic             busy_l2_r;
  logic [2:0]       pos;
  logic [2:0]       cnt;
  logic             byte_done;
  logic [7:0]       byte_val;
  logic             si;

  // only line 0 carries input; line 1 is ignored on input
  assign si        = bidir_data_lines_in[0];
  assign pos       = first_r ? 3'h0 : bit_pos_r;
  assign cnt       = first_r ? 3'h0 : byte_cnt_r;
  assign byte_done = (pos == 3'h7);
  assign byte_val  = {sh_r, si};

  // marks the next rising edge as the first of a frame
  always_ff @(posedge sclk or posedge cs_n or negedge resetn)
  begin
    if (!resetn || cs_n)
      first_r <= 1'b1;
    else
      first_r <= 1'b0;
  end

  always_ff @(posedge sclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sh_r        <= 7'h00;
      bit_pos_r   <= 3'h0;
      byte_cnt_r  <= 3'h0;
      opcode_r    <= 8'h00;
      addr_r      <= 24'h00_0000;
      frame_tog_r <= 1'b0;
    end
    else
    begin
      sh_r      <= {sh_r[5:0], si};
      bit_pos_r <= pos + 3'h1;
      if (first_r)
        frame_tog_r <= ~frame_tog_r;
      if (byte_done)
      begin
        byte_cnt_r <= (cnt == BYTE_CNT_MAX) ? BYTE_CNT_MAX : cnt + 3'h1;
        unique case (cnt)
          3'h0:    opcode_r      <= byte_val;
          3'h1:    addr_r[23:16] <= byte_val;
          3'h2:    addr_r[15:8]  <= byte_val;
          3'h3:    addr_r[7:0]   <= byte_val;
          default: addr_r        <= addr_r;
        endcase
      end
      else
        byte_cnt_r <= cnt;
    end
  end

  // busy level carried into the serial clock domain
  always_ff @(posedge sclk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_l1_r <= 1'b0;
      busy_l2_r <= 1'b0;
    end
    else
    begin
      busy_l1_r <= cycle_busy_flag;
      busy_l2_r <= busy_l1_r;
    end
  end

  // ==========================================================================
  // page buffer
  logic [7:0] page_mem_r  [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mark_r;
  logic [7:0] data_ptr_r;
  logic       pw_frame;

  // frozen while a cycle runs so the array reads stable data
  assign pw_frame = byte_done && (opcode_r == OP_PAGE_WRITE) && !busy_l2_r;

  always_ff @(posedge sclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mark_r     <= '0;
      data_ptr_r <= 8'h00;
    end
    else if (pw_frame && cnt == 3'h3)
    begin
      mark_r     <= '0;
      data_ptr_r <= byte_val;
    end
    else if (pw_frame && cnt >= ADDR_FRAME_BYTES)
    begin
      mark_r[data_ptr_r] <= 1'b1;
      data_ptr_r         <= data_ptr_r + 8'h01;
    end
  end

  always_ff @(posedge sclk)
  begin
    if (pw_frame && cnt >= ADDR_FRAME_BYTES)
      page_mem_r[data_ptr_r] <= byte_val;
  end

  // read port is quasi-static: written only outside a running cycle
  assign page_rd_data = page_mem_r[page_rd_idx];
  assign page_rd_mark = mark_r[page_rd_idx];

  // ==========================================================================
  // signature output, shifted on falling sclk
  logic sig_oe_r;
  logic sig_bit_r;

  always_ff @(negedge sclk or posedge cs_n or negedge resetn)
  begin
    if (cs_n || !resetn)
    begin
      sig_oe_r  <= 1'b0;
      sig_bit_r <= 1'b0;
    end
    else if (!first_r && opcode_r == OP_SIGNATURE
             && byte_cnt_r >= ADDR_FRAME_BYTES && !busy_l2_r)
    begin
      sig_oe_r  <= 1'b1;
      sig_bit_r <= SIGNATURE_VALUE[3'h7 - bit_pos_r];
    end
    else
    begin
      sig_oe_r  <= 1'b0;
      sig_bit_r <= 1'b0;
    end
  end

  assign bidir_data_lines_out = {sig_bit_r, 1'b0};
  assign bidir_data_lines_oe  = {sig_oe_r, 1'b0};

  // ==========================================================================
  // system clock domain: end-of-frame detection
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;
  logic tog_s1_r;
  logic tog_s2_r;
  logic tog_seen_r;
  logic frame_done;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_s1_r    <= 1'b1;
      cs_s2_r    <= 1'b1;
      cs_s3_r    <= 1'b1;
      tog_s1_r   <= 1'b0;
      tog_s2_r   <= 1'b0;
      tog_seen_r <= 1'b0;
    end
    else
    begin
      cs_s1_r  <= cs_n;
      cs_s2_r  <= cs_s1_r;
      cs_s3_r  <= cs_s2_r;
      tog_s1_r <= frame_tog_r;
      tog_s2_r <= tog_s1_r;
      if (cs_s2_r && !cs_s3_r)
        tog_seen_r <= tog_s2_r;
    end
  end

  // frame registers are stable here: sclk has stopped with cs_n high
  assign frame_done = cs_s2_r && !cs_s3_r && (tog_s2_r != tog_seen_r);

  // ==========================================================================
  // command decode at the end of a frame
  logic        aligned;
  logic        is_unlock;
  logic        is_half;
  logic        is_full;
  logic        is_whole;
  logic        is_page;
  logic        is_sleep;
  logic        is_release;
  logic [23:0] last_addr;
  logic        protected_hit;
  logic [31:0] prot_span;
  logic [24:0] prot_base;

  assign aligned = (bit_pos_r == 3'h0);
  assign is_half  = aligned && opcode_r == OP_HALF_BLOCK_ERASE
                    && byte_cnt_r == ADDR_FRAME_BYTES;
  assign is_full  = aligned && opcode_r == OP_FULL_BLOCK_ERASE
                    && byte_cnt_r == ADDR_FRAME_BYTES;
  assign is_whole = aligned && opcode_r == OP_ARRAY_ERASE
                    && byte_cnt_r == OPCODE_ONLY_BYTES;
  // at least one whole data byte
  assign is_page  = aligned && opcode_r == OP_PAGE_WRITE
                    && byte_cnt_r >= FIRST_DATA_BYTES;
  assign is_sleep = aligned && opcode_r == OP_SLEEP_ENTRY
                    && byte_cnt_r == OPCODE_ONLY_BYTES;
  assign is_unlock = aligned && opcode_r == OP_WRITE_UNLOCK
                     && byte_cnt_r == OPCODE_ONLY_BYTES;
  assign is_release = opcode_r == OP_SIGNATURE && byte_cnt_r >= OPCODE_ONLY_BYTES;

  always_comb
  begin
    if (is_half)
      last_addr = addr_r | HALF_BLOCK_MASK;
    else if (is_full)
      last_addr = addr_r | FULL_BLOCK_MASK;
    else
      last_addr = addr_r | PAGE_MASK;
  end

  // protected region is the top of the array, doubling per code step
  always_comb
  begin
    prot_span = PROTECT_UNIT << (protect_range_bits - 4'h1);
    if (protect_range_bits == 4'h0)
      prot_base = {1'b0, ARRAY_BYTES};
    else if (prot_span >= {8'h00, ARRAY_BYTES} || protect_range_bits > 4'h8)
      prot_base = 25'h000_0000;
    else
      prot_base = {1'b0, ARRAY_BYTES} - prot_span[24:0];
  end

  // array erase needs all protect bits zero
  assign protected_hit = is_whole ? (protect_range_bits != 4'h0)
                                  : ({1'b0, last_addr} >= prot_base);

  // ==========================================================================
  // device state and cycle timer
  dev_state_e  state_r;
  logic [31:0] timer_r;
  logic        start_ok;
  logic        write_cmd;
  logic        timer_zero;

  assign write_cmd  = is_half || is_full || is_whole || is_page;
  // no erase or page write starts without the unlock latch
  assign start_ok   = write_cmd && write_unlock_latch && !protected_hit;
  assign timer_zero = (timer_r == 32'h0000_0000);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_STANDBY;
      timer_r <= 32'h0000_0000;
    end
    else
    begin
      unique case (state_r)
        ST_STANDBY:
        begin
          if (frame_done && start_ok)
          begin
            state_r <= ST_BUSY;
            if (is_half)
              timer_r <= 32'(HALF_BLOCK_ERASE_CNT);
            else if (is_full)
              timer_r <= 32'(FULL_BLOCK_ERASE_CNT);
            else if (is_whole)
              timer_r <= 32'(ARRAY_ERASE_CNT);
            else
              timer_r <= 32'(PAGE_WRITE_CNT);
          end
          else if (frame_done && is_sleep)
          begin
            state_r <= ST_SLEEP_ENTER;
            timer_r <= SLEEP_ENTRY_CYCLES;
          end
        end
        ST_BUSY:
        begin
          timer_r <= timer_r - 32'h0000_0001;
          if (timer_r == 32'h0000_0001)
            state_r <= ST_STANDBY;
        end
        ST_SLEEP_ENTER:
        begin
          timer_r <= timer_r - 32'h0000_0001;
          if (timer_r == 32'h0000_0001)
            state_r <= ST_SLEEP;
        end
        ST_SLEEP:
        begin
          if (frame_done && is_release)
          begin
            state_r <= ST_SLEEP_EXIT;
            timer_r <= SLEEP_EXIT_CYCLES;
          end
        end
        ST_SLEEP_EXIT:
        begin
          timer_r <= timer_r - 32'h0000_0001;
          if (timer_r == 32'h0000_0001)
            state_r <= ST_STANDBY;
        end
      endcase
    end
  end

  assign cycle_busy_flag = (state_r == ST_BUSY);
  assign sleep_state     = (state_r == ST_SLEEP_ENTER) || (state_r == ST_SLEEP)
                           || (state_r == ST_SLEEP_EXIT);

  // ==========================================================================
  // write unlock latch
  logic cycle_end;
  logic reject_clear;

  assign cycle_end    = (state_r == ST_BUSY) && (timer_r == 32'h0000_0001);
  // protected target still drops the latch
  assign reject_clear = (state_r == ST_STANDBY) && frame_done && write_cmd
                        && write_unlock_latch && protected_hit;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      write_unlock_latch <= 1'b0;
    else if ((state_r == ST_STANDBY) && frame_done && is_unlock)
      write_unlock_latch <= 1'b1;
    else if (cycle_end || reject_clear)
      write_unlock_latch <= 1'b0;
  end

  // ==========================================================================
  // array operation request
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      array_start <= 1'b0;
      array_kind  <= ARR_HALF_BLOCK;
      array_addr  <= 24'h00_0000;
    end
    else
    begin
      // protected targets never reach the array
      array_start <= (state_r == ST_STANDBY) && frame_done && start_ok;
      if ((state_r == ST_STANDBY) && frame_done && start_ok)
      begin
        array_addr <= addr_r;
        if (is_half)
          array_kind <= ARR_HALF_BLOCK;
        else if (is_full)
          array_kind <= ARR_FULL_BLOCK;
        else if (is_whole)
          array_kind <= ARR_WHOLE;
        else
          array_kind <= ARR_PAGE;
      end
    end
  end

endmodule

`default_nettype wire

/* File: bench/flash_seq_checker.sv */
// checker: timing relations at the sequencer's ports
// assumes binding to flash_cmd_seq with the bus-cycle counts above 8
`default_nettype none

module flash_seq_checker
  import flash_seq_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire logic                  cs_n,
  input wire logic [1:0]            bidir_data_lines_out,
  input wire logic [1:0]            bidir_data_lines_oe,
  input wire logic [3:0]            protect_range_bits,
  input wire logic                  write_unlock_latch,
  input wire logic                  cycle_busy_flag,
  input wire logic                  sleep_state,
  input wire logic                  array_start,
  input wire flash_seq_pkg::array_op_e array_kind,
  input wire logic [ADDR_W-1:0]     array_addr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ==========================================================================
  // assertions
  chk_start_needs_latch: assert property (
    array_start |-> write_unlock_latch && cycle_busy_flag) else $error("start without latch");
  chk_busy_then_start: assert property (
    $rose(cycle_busy_flag) |-> ##[0:1] array_start) else $error("busy without start");
  chk_busy_holds: assert property (
    $rose(cycle_busy_flag) |=> cycle_busy_flag [*8]) else $error("busy dropped early");
  chk_done_unlocks: assert property (
    $fell(cycle_busy_flag) |-> !write_unlock_latch) else $error("latch kept after cycle");
  chk_latch_busy: assert property (
    cycle_busy_flag |-> write_unlock_latch) else $error("latch clear while busy");
  chk_whole_unprot: assert property (
    array_start && array_kind == ARR_WHOLE |-> protect_range_bits == 4'h0)
    else $error("array erase with protection");
  chk_sleep_idle: assert property (
    sleep_state |-> !array_start && !cycle_busy_flag) else $error("activity while asleep");
  chk_sig_select: assert property (
    bidir_data_lines_oe[1] |-> !cs_n && !cycle_busy_flag) else $error("readout drive wrong");
  chk_spare_line: assert property (
    !bidir_data_lines_oe[0] && !bidir_data_lines_out[0]) else $error("line zero driven");
  chk_start_pulse: assert property (
    array_start |=> !array_start && $stable(array_addr)) else $error("start not a pulse");
endmodule

bind flash_cmd_seq flash_seq_checker u_chk (
  .clk                 (clk),
  .resetn              (resetn),
  .cs_n                (cs_n),
  .bidir_data_lines_out(bidir_data_lines_out),
  .bidir_data_lines_oe (bidir_data_lines_oe),
  .protect_range_bits  (protect_range_bits),
  .write_unlock_latch  (write_unlock_latch),
  .cycle_busy_flag     (cycle_busy_flag),
  .sleep_state         (sleep_state),
  .array_start         (array_start),
  .array_kind          (array_kind),
  .array_addr          (array_addr)
);

`default_nettype wire

/* File: bench/flash_host_model.sv */
// host controller model: frames commands on cs_n, sclk and the data lines
// assumes an 80 ns serial clock that stands still between frames
`default_nettype none

module flash_host_model
(
  output logic       sclk,
  output logic       cs_n,
  output logic [1:0] data_in,
  input  wire logic  sig_bit,
  output logic [15:0] rd_word
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    data_in = 2'h1;
    rd_word = 16'h0000;
  end

  // ==========================================================================
  // one frame: low nbits of bits MSB first, then nread readout clocks
  // opcode, address and data in any count of bits, cs rise ends it
  task automatic frame(input logic [63:0] bits, input int nbits, input int nread);
    #3 cs_n = 1'b0;
    #40;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      // bit set up before rising edge, spare line toggles
      data_in = {~data_in[1], bits[i]};
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    for (int i = 0; i < nread; i++)
    begin
      data_in = ~data_in;
      #40 sclk = 1'b1;
      rd_word = {rd_word[14:0], sig_bit};
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    data_in = ~data_in;
    #200;
  endtask
endmodule

`default_nettype wire

/* File: bench/serial_flash_erase_program_power_tb.sv */
// testbench: erase, page write, sleep and signature through the serial link
// assumes the host model frames commands and the checker is bound
`default_nettype none

module serial_flash_erase_program_power_tb;
  import flash_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CNT    = 20;
  localparam int CE_CNT = 400;

  logic        clk = 1'b0;
  logic        resetn;
  logic        sclk;
  logic        cs_n;
  logic [1:0]  host_d;
  logic [1:0]  lines_in;
  logic [1:0]  lines_out;
  logic [1:0]  lines_oe;
  logic [3:0]  prot = 4'h0;
  logic        latch;
  logic        busy;
  logic        sleep;
  logic        start;
  array_op_e   kind;
  logic [23:0] addr;
  logic [7:0]  idx = 8'h00;
  logic [7:0]  rdata;
  logic        rmark;
  logic [15:0] rd_word;
  int          num_errors = 0;
  int          n_compared = 0;
  int          starts = 0;
  int          busy_run = 0;
  int          busy_len = 0;
  int          oe_cnt = 0;
  array_op_e   seen_kind;
  logic [23:0] seen_addr;

  always #5 clk = ~clk;
  assign lines_in = {lines_oe[1] ? lines_out[1] : host_d[1], host_d[0]};

  flash_cmd_seq #(.HALF_BLOCK_ERASE_CNT(CNT), .FULL_BLOCK_ERASE_CNT(CNT),
    .ARRAY_ERASE_CNT(CE_CNT), .PAGE_WRITE_CNT(CNT)) u_flash_cmd_seq (
    .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
    .bidir_data_lines_in(lines_in), .bidir_data_lines_out(lines_out),
    .bidir_data_lines_oe(lines_oe), .protect_range_bits(prot),
    .write_unlock_latch(latch), .cycle_busy_flag(busy), .sleep_state(sleep),
    .array_start(start), .array_kind(kind), .array_addr(addr),
    .page_rd_idx(idx), .page_rd_data(rdata), .page_rd_mark(rmark));

  flash_host_model u_host (.sclk(sclk), .cs_n(cs_n), .data_in(host_d),
    .sig_bit(lines_in[1]), .rd_word(rd_word));

  // ==========================================================================
  // port monitor
  always @(posedge clk)
  begin
    if (start === 1'b1)
    begin
      starts <= starts + 1;
      seen_kind <= kind;
      seen_addr <= addr;
    end
    if (busy === 1'b1)
      busy_run <= busy_run + 1;
    else if (busy_run != 0)
    begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
    if (lines_oe[1] === 1'b1)
      oe_cnt <= oe_cnt + 1;
  end

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    check("idle in time", 32'(n < lim), 1);
    @(posedge clk);
  endtask

  task automatic op(input logic [63:0] bits, input int nbits, input logic go,
                    input array_op_e k, input logic [23:0] a, input logic lat);
    int s;
    s = starts;
    u_host.frame(bits, nbits, 0);
    wait_idle(CNT + 50);
    check("starts", 32'(starts - s), {31'h0, go});
    if (go)
    begin
      check("kind", seen_kind, k);
      check("addr", seen_addr, a);
      check("busy length", busy_len >= CNT && busy_len <= CNT + 2, 1);
    end
    check("latch after", latch, lat);
  endtask

  task automatic unlock;
    u_host.frame(64'h06, 8, 0);
  endtask

  task automatic rd_page(input logic [7:0] i, input logic [7:0] d, input logic m);
    @(posedge clk) idx <= i;
    @(posedge clk);
    check("page byte", rdata, d);
    check("page mark", rmark, m);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_erase;
    op({8'h52, 24'h01_2345}, 32, 0, ARR_HALF_BLOCK, 24'h0, 0);
    unlock();
    check("latch set", latch, 1);
    op({8'h52, 24'h01_2345} >> 1, 31, 0, ARR_HALF_BLOCK, 24'h0, 1);
    op({8'h52, 24'h01_2345}, 32, 1, ARR_HALF_BLOCK, 24'h01_2345, 0);
    unlock();
    op({8'hd8, 24'h00_abcd}, 32, 1, ARR_FULL_BLOCK, 24'h00_abcd, 0);
  endtask

  task automatic t_protect;
    @(posedge clk) prot <= 4'h1;
    unlock();
    op({8'h52, 24'h01_f000}, 32, 0, ARR_HALF_BLOCK, 24'h0, 0);
    unlock();
    op({8'hd8, 24'h01_0000}, 32, 0, ARR_FULL_BLOCK, 24'h0, 0);
    unlock();
    op(64'h60, 8, 0, ARR_WHOLE, 24'h0, 0);
    unlock();
    op({8'h02, 24'h01_f010, 8'h00}, 40, 0, ARR_PAGE, 24'h0, 0);
    unlock();
    op({8'h52, 24'h00_0000}, 32, 1, ARR_HALF_BLOCK, 24'h00_0000, 0);
    @(posedge clk) prot <= 4'h0;
  endtask

  task automatic t_page;
    unlock();
    // partial page, offset need not be zero
    op({8'h02, 24'h00_00fe, 24'haa_bbcc}, 56, 1, ARR_PAGE, 24'h00_00fe, 0);
    rd_page(8'hfe, 8'haa, 1);
    rd_page(8'hff, 8'hbb, 1);
    rd_page(8'h00, 8'hcc, 1);
    rd_page(8'h10, 8'h00, 0);
    unlock();
    op({8'h02, 24'h00_0010, 8'h11, 4'h5}, 44, 0, ARR_PAGE, 24'h0, 1);
  endtask

  task automatic t_busy;
    int s;
    int o;
    s = starts;
    u_host.frame(64'h60, 8, 0);
    o = oe_cnt;
    u_host.frame({8'hab, 24'h00_0000}, 32, 8);
    check("readout while busy", 32'(oe_cnt - o), 0);
    check("still busy", busy, 1);
    wait_idle(CE_CNT + 50);
    check("whole erase start", 32'(starts - s), 1);
    check("whole kind", seen_kind, ARR_WHOLE);
    check("latch cleared", latch, 0);
  endtask

  task automatic t_signature;
    int o;
    o = oe_cnt;
    // legacy read kept for this check and for the busy check in t_busy
    u_host.frame({8'hab, 24'h00_0000}, 32, 16);
    check("signature twice", rd_word, {SIGNATURE_VALUE, SIGNATURE_VALUE});
    check("readout driven", 32'(oe_cnt > o), 1);
  endtask

  task automatic t_sleep;
    int n;
    u_host.frame({8'hb9, 1'b0}, 9, 0);
    check("no sleep on 9 bits", sleep, 0);
    u_host.frame(64'hb9, 8, 0);
    check("sleep entered", sleep, 1);
    repeat (1100) @(posedge clk);
    unlock();
    check("unlock ignored", latch, 0);
    u_host.frame(64'hab, 8, 0);
    repeat (2900) @(posedge clk);
    check("exit delay", sleep, 1);
    n = 0;
    while (sleep !== 1'b0 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    check("exit done", sleep, 0);
  endtask

  task automatic t_reset_sleep;
    u_host.frame(64'hb9, 8, 0);
    repeat (1100) @(posedge clk);
    @(posedge clk) resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check("reset wakes", sleep, 0);
  endtask

  // ==========================================================================
  // run
  task automatic results;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_erase();
    t_protect();
    t_page();
    unlock();
    t_busy();
    t_signature();
    t_sleep();
    t_reset_sleep();
    results();
  end

  initial
  begin
    #500us;
    num_errors++;
    results();
  end
endmodule

`default_nettype wire
